/* File: design/burst_sram_pkg.sv */
// Purpose: shared constants for the pipelined burst sram access block
// Assumes: 32-bit words, four byte lanes, two-bit burst counter
// Notes:   sleep timing is expressed in clock cycles
package burst_sram_pkg;
    localparam int ADDR_W          = 15;
    localparam int DATA_W          = 32;
    localparam int LANES           = 4;
    localparam int BURST_W         = 2;
    // sleep entry and recovery, in clock periods
    localparam int SLEEP_ENTRY_CYC = 2;
    localparam int SLEEP_REC_CYC   = 2;
    localparam logic [1:0] SLEEP_CNT_MAX = 2'h3;
    // burst order strap levels
    localparam logic ORDER_LINEAR      = 1'b0;
    localparam logic ORDER_INTERLEAVED = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } access_state_t;
endpackage : burst_sram_pkg

/* File: design/burst_addr_gen.sv */
// Purpose: two-bit wraparound burst counter with order select
// Assumes: load and step are mutually exclusive, load wins
// Notes:   beat index counts up, address derived from start and index
`timescale 1ns/1ns
module burst_addr_gen
    import burst_sram_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 load_i,
    input  wire logic                 step_i,
    input  wire logic                 order_i,
    input  wire logic [BURST_W-1:0]   start_i,
    output logic      [BURST_W-1:0]   low_addr_o
);
    logic [BURST_W-1:0] start_q;
    logic [BURST_W-1:0] beat_q;

    // load start value, then step beat index; hold when neither
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            start_q <= '0;
            beat_q  <= '0;
        end
        else if (load_i)
        begin
            start_q <= start_i;
            beat_q  <= '0;
        end
        else if (step_i)
        begin
            beat_q <= beat_q + 2'h1;
        end
    end

    // order choice: xor for interleaved, modulo add for linear
    always_comb
    begin
        if (order_i == ORDER_INTERLEAVED)
            low_addr_o = start_q ^ beat_q;
        else
            low_addr_o = start_q + beat_q;
    end
endmodule : burst_addr_gen

/* File: design/burst_sram_access.sv */
// What this block does
// - read starts on strobe, all selects active, write enables high
// - address captured at access start and used by core same cycle
// - read data registered next clock, driven only while drive enable low
// - first cycle after leaving deselect keeps outputs off
// - back-to-back reads accepted; then drive enable alone gates outputs
// - deselect by select plus strobe turns outputs off from the next clock
// - processor strobe cycle ignores write controls and burst advance
// - processor strobe write completes at second clock with global write
// - byte write stores only lanes whose select is low
// - outputs off whenever a write cycle is detected
// - controller strobe write completes in one clock, advance ignored
// - global write stores all bytes, byte write selected lanes only
// - two-bit burst counter loaded from low address bits
// - burst advance low steps counter, for reads and writes
// - interleaved order is start xor beat index
// - linear order counts up modulo four
// - burst order picked by order select input
// - sleep request asynchronous; entry and exit take two clocks
// - stored data kept in sleep; pending accesses may be dropped
// - both strobes low: processor strobe acts; with first select off the controller strobe deselects
// - order select low linear, high interleaved, static
// Purpose: access control and storage of a pipelined burst sram
// Assumes: inputs synchronous to clk_i except sleep_request_i and output_enable_n_i
// Notes:   the data pin is split into in, out and output enable
`timescale 1ns/1ns
module burst_sram_access
    import burst_sram_pkg::*;
#(
    parameter int AW = ADDR_W
)
(
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 proc_addr_strobe_n_i,
    input  wire logic                 ctrl_addr_strobe_n_i,
    input  wire logic                 burst_advance_n_i,
    input  wire logic                 global_write_n_i,
    input  wire logic                 byte_write_enable_n_i,
    input  wire logic [LANES-1:0]     byte_lane_select_n_i,
    input  wire logic                 chip_sel_a_n_i,
    input  wire logic                 chip_sel_b_i,
    input  wire logic                 chip_sel_c_n_i,
    input  wire logic                 output_enable_n_i,
    input  wire logic                 burst_order_i,
    input  wire logic                 sleep_request_i,
    input  wire logic [AW-1:0]        addr_i,
    input  wire logic [DATA_W-1:0]    data_i,
    output logic      [DATA_W-1:0]    data_o,
    output logic                      data_oe_o,
    output logic                      asleep_o
);
    import burst_sram_pkg::*;

    logic [DATA_W-1:0]  mem_q [0:(1<<AW)-1];
    access_state_t      state_q;
    logic [AW-1:0]      addr_q;
    logic [DATA_W-1:0]  rdata_q;
    logic               rvalid_q;
    logic [DATA_W-1:0]  dout_q;
    logic               dvalid_q;
    logic               first_q;
    logic               sleep_meta_q;
    logic               sleep_sync_q;
    logic [1:0]         sleep_cnt_q;
    logic               asleep_q;
    logic [1:0]         low_addr;
    logic               sel_all;
    logic               proc_start;
    logic               ctrl_start;
    logic               start;
    logic               deselect;
    logic               any_write;
    logic               cont;
    logic               step;
    logic [AW-1:0]      core_addr;
    logic [LANES-1:0]   lane_we;
    logic               do_write;

    // decode of strobes and selects; processor strobe needs first select low
    assign sel_all    = !chip_sel_a_n_i && chip_sel_b_i && !chip_sel_c_n_i;
    assign proc_start = !proc_addr_strobe_n_i && sel_all && !asleep_q;
    assign ctrl_start = proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i
                        && sel_all && !asleep_q;
    assign start      = proc_start || ctrl_start;
    // deselect: controller strobe with any select off, or processor strobe
    // with first select low but another off
    assign deselect   = (!ctrl_addr_strobe_n_i && !sel_all)
                        || (!proc_addr_strobe_n_i && !chip_sel_a_n_i && !sel_all);
    assign any_write  = !global_write_n_i
                        || (!byte_write_enable_n_i && (byte_lane_select_n_i != 4'hF));
    assign cont       = proc_addr_strobe_n_i && ctrl_addr_strobe_n_i
                        && (state_q != ST_IDLE) && !asleep_q;
    assign step       = cont && !burst_advance_n_i;

    // burst counter sits in its own module
    burst_addr_gen u_burst
    (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .load_i     (start),
        .step_i     (step),
        .order_i    (burst_order_i),
        .start_i    (addr_i[1:0]),
        .low_addr_o (low_addr)
    );

    // core address: fresh address in start cycle, else registered burst address
    always_comb
    begin
        if (start)
            core_addr = addr_i;
        else
            core_addr = {addr_q[AW-1:2], low_addr};
    end

    // lane enables: global write wins over byte controls
    always_comb
    begin
        lane_we  = '0;
        do_write = 1'b0;
        if (proc_start)
        begin
            lane_we = '0;
        end
        else if (ctrl_start || cont)
        begin
            if (!global_write_n_i)
                lane_we = 4'hF;
            else if (!byte_write_enable_n_i)
                lane_we = ~byte_lane_select_n_i;
        end
        do_write = (lane_we != 4'h0);
    end

    // access state: idle, read burst, write burst
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state_q <= ST_IDLE;
        else if (asleep_q || deselect)
            state_q <= ST_IDLE;
        else if (start || cont)
        begin
            case (1'b1)
                do_write: state_q <= ST_WRITE;
                default:  state_q <= ST_READ;
            endcase
        end
    end

    // address register captures the access address
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            addr_q <= '0;
        else if (start)
            addr_q <= addr_i;
    end

    // storage; sleep never touches contents, only blocks new writes
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < LANES; i++)
        begin
            if (lane_we[i] && !asleep_q)
                mem_q[core_addr][8*i +: 8] <= data_i[8*i +: 8];
        end
    end

    // output register: read data appears the clock after the address
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end
        else if (deselect || asleep_q)
        begin
            rvalid_q <= 1'b0;
        end
        else if (start || cont)
        begin
            rdata_q  <= mem_q[core_addr];
            rvalid_q <= !do_write;
        end
    end

    // pin stage: core word reaches the pins one rise after the address capture
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dout_q   <= '0;
            dvalid_q <= 1'b0;
        end
        else if (deselect || asleep_q)
        begin
            dvalid_q <= 1'b0;
        end
        else
        begin
            dout_q   <= rdata_q;
            dvalid_q <= rvalid_q;
        end
    end

    // first-cycle mask when emerging from deselect; stale pin data hidden
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            first_q <= 1'b0;
        else
            first_q <= start && (state_q == ST_IDLE);
    end

    // sleep request synchroniser; second stage alone feeds logic
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sleep_meta_q <= 1'b0;
            sleep_sync_q <= 1'b0;
        end
        else
        begin
            sleep_meta_q <= sleep_request_i;
            sleep_sync_q <= sleep_meta_q;
        end
    end

    // two-cycle entry and exit; the sync stage supplies the delay
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            asleep_q    <= 1'b0;
            sleep_cnt_q <= '0;
        end
        else if (sleep_sync_q != asleep_q)
        begin
            if (sleep_cnt_q == 2'(SLEEP_ENTRY_CYC - 2))
            begin
                asleep_q    <= sleep_sync_q;
                sleep_cnt_q <= '0;
            end
            else if (sleep_cnt_q != SLEEP_CNT_MAX)
                sleep_cnt_q <= sleep_cnt_q + 2'h1;
        end
        else
            sleep_cnt_q <= '0;
    end

    // pins: data from register, enable combinational from async drive enable;
    // a detected write turns drivers off whatever the drive enable says
    assign data_o    = dout_q;
    assign data_oe_o = dvalid_q && !first_q && !output_enable_n_i
                       && !asleep_q && !do_write;
    assign asleep_o  = asleep_q;
endmodule : burst_sram_access

/* File: test/burst_sram_sva.sv */
// Purpose: port checks of the burst sram access block
// Assumes: select a alone is used to deselect
// Notes:   sleep sync latency allowed two to four edges
`timescale 1ns/1ns
module burst_sram_sva
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic proc_addr_strobe_n_i,
    input wire logic ctrl_addr_strobe_n_i,
    input wire logic global_write_n_i,
    input wire logic byte_write_enable_n_i,
    input wire logic chip_sel_a_n_i,
    input wire logic chip_sel_b_i,
    input wire logic chip_sel_c_n_i,
    input wire logic output_enable_n_i,
    input wire logic sleep_request_i,
    input wire logic data_oe_o,
    input wire logic asleep_o
);
    // decoded pin conditions
    wire logic sel = !chip_sel_a_n_i && chip_sel_b_i && !chip_sel_c_n_i;
    wire logic wr  = !global_write_n_i || !byte_write_enable_n_i;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_desel;
        !ctrl_addr_strobe_n_i && chip_sel_a_n_i;
    endsequence
    // processor strobe reads whatever the write pins say
    sequence s_start;
        sel && (!proc_addr_strobe_n_i || (!ctrl_addr_strobe_n_i && !wr));
    endsequence
    a_write_no_drive: assert property (proc_addr_strobe_n_i && !global_write_n_i |-> !data_oe_o)
        else $error("outputs driven in a write cycle");
    a_oe_gate: assert property (output_enable_n_i |-> !data_oe_o)
        else $error("outputs driven with drive enable high");
    a_desel_off: assert property (s_desel |=> !data_oe_o)
        else $error("outputs driven after deselect");
    a_first_mask: assert property (s_desel ##1 s_start |=> !data_oe_o)
        else $error("first cycle after deselect not masked");
    a_back_to_back: assert property (s_start ##1 s_start |=> ##1 (output_enable_n_i || wr || data_oe_o))
        else $error("second read not driven");
    a_sleep_entry: assert property ($rose(sleep_request_i) |-> ##[2:4] asleep_o)
        else $error("sleep entry late");
    a_sleep_exit: assert property ($fell(sleep_request_i) |-> ##[2:4] !asleep_o)
        else $error("sleep exit late");
    a_sleep_quiet: assert property (asleep_o |-> !data_oe_o)
        else $error("outputs driven while asleep");
endmodule : burst_sram_sva

bind burst_sram_access burst_sram_sva burst_sram_sva_i (.*);

/* File: test/sram_master_model.sv */
// Purpose: processor or cache controller side of the sram pins
// Assumes: requests change just after the rising edge, held a period
// Notes:   unwritten data lines show the inverse of the last value
`timescale 1ns/1ns
module sram_master_model
(
    input  wire logic                       clk_i,
    output logic [1:0]                      strobe_n_o,
    output logic                            advance_n_o,
    output logic [5:0]                      write_n_o,
    output logic                            sel_a_n_o,
    output logic                            drive_en_n_o,
    output logic [burst_sram_pkg::ADDR_W-1:0] addr_o,
    output logic [burst_sram_pkg::DATA_W-1:0] data_o
);
    import burst_sram_pkg::*;
    // idle and selected at time zero
    initial
    begin
        strobe_n_o = 2'h3;
        advance_n_o = 1'b1;
        write_n_o = 6'h3F;
        sel_a_n_o = 1'b0;
        drive_en_n_o = 1'b0;
        addr_o = '0;
        data_o = '0;
    end
    // one bus cycle; writes release the device drivers in that same cycle
    task automatic cyc(input logic [1:0] st, input logic v, input logic [5:0] w,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic s);
        @(posedge clk_i);
        strobe_n_o <= st;
        advance_n_o <= v;
        write_n_o <= w;
        sel_a_n_o <= s;
        drive_en_n_o <= ~&w[5:4];
        addr_o <= a;
        data_o <= &w[5:4] ? ~data_o : d;
    endtask : cyc
endmodule : sram_master_model

/* File: test/burst_sram_access_tb.sv */
// Purpose: self-checking bench for the burst sram access block
// Assumes: selects b and c held active, select a deselects
// Notes:   expected words kept in a four-entry array
`timescale 1ns/1ns
module burst_sram_access_tb;
    import burst_sram_pkg::*;
    localparam logic [5:0]  RD   = 6'h3F;
    localparam logic [5:0]  WR_ALL = 6'h1F;
    localparam logic [14:0] BASE = 15'h0124;
    logic                   clk_i           = 1'b0;
    logic                   resetn_i        = 1'b0;
    logic                   burst_order_i   = 1'b0;
    logic                   sleep_request_i = 1'b0;
    logic                   chip_sel_b_i    = 1'b1;
    logic                   chip_sel_c_n_i  = 1'b0;
    wire logic              proc_addr_strobe_n_i, ctrl_addr_strobe_n_i, burst_advance_n_i;
    wire logic              global_write_n_i, byte_write_enable_n_i, chip_sel_a_n_i;
    wire logic              output_enable_n_i, data_oe_o, asleep_o;
    wire logic [LANES-1:0]  byte_lane_select_n_i;
    wire logic [ADDR_W-1:0] addr_i;
    wire logic [DATA_W-1:0] data_i, data_o;
    logic [DATA_W-1:0]      mem [4];
    int                     err_count = 0;
    int                     n_checks  = 0;
    // free-running 50 MHz clock
    always #10 clk_i = ~clk_i;
    burst_sram_access burst_sram_access_i (.*);
    sram_master_model sram_master_model_i (
        .clk_i       (clk_i),
        .strobe_n_o  ({proc_addr_strobe_n_i, ctrl_addr_strobe_n_i}),
        .advance_n_o (burst_advance_n_i),
        .write_n_o   ({global_write_n_i, byte_write_enable_n_i, byte_lane_select_n_i}),
        .sel_a_n_o   (chip_sel_a_n_i),
        .drive_en_n_o(output_enable_n_i),
        .addr_o      (addr_i),
        .data_o      (data_i)
    );
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic mc(input logic [1:0] st, input logic v, input logic [5:0] w,
                      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic s);
        sram_master_model_i.cyc(st, v, w, a, d, s);
    endtask : mc
    task automatic ds;
        mc(2'b10, 1'b1, RD, '0, '0, 1'b1);
    endtask : ds
    function automatic logic [1:0] beat(input logic [1:0] s, input logic [1:0] b);
        return (burst_order_i == ORDER_INTERLEAVED) ? s ^ b : s + b;
    endfunction : beat
    // controller strobe write; advance held low to show it is ignored
    task automatic cw(input logic [1:0] lo, input logic [5:0] w, input logic [DATA_W-1:0] d);
        mc(2'b10, 1'b0, w, BASE | 15'(lo), d, 1'b0);
        #1 chk(data_oe_o, 1'b0);
        for (int i = 0; i < LANES; i++)
            if (!w[5] || (!w[4] && !w[i])) mem[lo][8*i +: 8] = d[8*i +: 8];
    endtask : cw
    // start from deselect, one suspend, then a wrapping burst
    task automatic rd(input logic [1:0] st, input logic [1:0] lo);
        mc(st, 1'b1, RD, BASE | 15'(lo), '0, 1'b0);
        mc(2'b11, 1'b1, RD, '0, '0, 1'b0);
        #1 chk(data_oe_o, 1'b0);
        mc(2'b11, 1'b0, RD, '0, '0, 1'b0);
        #1 chk(data_o, mem[lo]);
        chk(data_oe_o, 1'b1);
        for (int b = 0; b < 5; b++)
        begin
            mc(b < 4 ? 2'b11 : 2'b10, b == 4, RD, '0, '0, b == 4);
            #1 chk(data_o, mem[beat(lo, (b == 0) ? 2'h0 : b[1:0] - 2'h1)]);
        end
        $display("test burst done");
    endtask : rd
    task automatic wt(input logic v);
        #1;
        for (int i = 0; i < 8 && asleep_o !== v; i++)
            #20;
        chk(asleep_o, v);
        if (asleep_o !== v) finish_test();
    endtask : wt
    // main sequence
    initial
    begin
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        ds();
        for (int i = 0; i < 4; i++)
            cw(i[1:0], WR_ALL, 32'h1234_5678 + 32'h1111_1111 * i);
        cw(2'h1, 6'h2A, 32'hA5A5_A5A5);
        mc(2'b01, 1'b0, WR_ALL, BASE | 15'h2, '0, 1'b0);
        mc(2'b11, 1'b1, WR_ALL, '0, 32'hC0DE_0002, 1'b0);
        mem[2] = 32'hC0DE_0002;
        mc(2'b00, 1'b1, WR_ALL, BASE | 15'h3, 32'hDEAD_BEEF, 1'b0);
        ds();
        $display("test writes done");
        mc(2'b01, 1'b1, RD, BASE, '0, 1'b0);
        mc(2'b10, 1'b1, RD, BASE | 15'h1, '0, 1'b0);
        mc(2'b11, 1'b1, RD, '0, '0, 1'b0);
        #1 chk(data_o, mem[0]);
        mc(2'b11, 1'b1, RD, '0, '0, 1'b0);
        #1 chk(data_o, mem[1]);
        chk(data_oe_o, 1'b1);
        ds();
        $display("test back to back done");
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk_i) burst_order_i <= k[2];
            rd(k[0] ? 2'b10 : 2'b01, k[1:0]);
        end
        @(posedge clk_i) sleep_request_i <= 1'b1;
        wt(1'b1);
        chk(data_oe_o, 1'b0);
        @(posedge clk_i) sleep_request_i <= 1'b0;
        wt(1'b0);
        mc(2'b11, 1'b1, RD, '0, '0, 1'b1);
        mc(2'b11, 1'b1, RD, '0, '0, 1'b1);
        ds();
        rd(2'b01, 2'h1);
        finish_test();
    end
endmodule : burst_sram_access_tb
